// ==== core/transceiver_mgmt_rate_select.sv ====
// How it works
// RL1 - byte 117 bit 0 selects 8G rate
// RL2 - byte 111 bit 0 bypasses clock recovery
// RL3 - reset returns 10G rate, recovery active
// RL4 - host alone drives the serial clock
// RL5 - data captured on rising clock edge
// RL6 - returned data changes on falling edge
// RL7 - data line shared, open drain
// RL8 - host frames transfers with start, stop
// RL9 - byte memory, random and sequential access
// RL10 - live measurements readable through memory
// RL11 - alarm, warning flags track factory limits
// RL12 - protected writes ignored, transfer still acked
`timescale 1ns/100ps
`include "mgmt_defs.svh"

module transceiver_mgmt_rate_select
  import mgmt_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire monitors_s monitors,
  output logic rate_8g,
  output logic cdr_bypass,
  output logic alarm_any,
  output logic warn_any
);

  if (DEV_ADDR < 7'h08) begin : g_check
    $error("device address falls in the reserved range");
  end

  // --------------------------------------------------------------
  // pin sampling and edge finding
  // --------------------------------------------------------------
  logic scl_s, sda_s, scl_d, sda_d;

  // RL4 clock from host
  pin_sync #(.WIDTH(2)) u_sync (.clk(clk), .rst_n(rst_n), .pin({scl, sda_in}),
    .sync({scl_s, sda_s}));

  // delayed copies; idle level high so reset brings no false edge
  always_ff @(posedge clk) begin
    if (!rst_n) {scl_d, sda_d} <= 2'h3;
    else {scl_d, sda_d} <= {scl_s, sda_s};
  end

  // RL8 start and stop framing
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // --------------------------------------------------------------
  // link engine
  // --------------------------------------------------------------
  link_state_e st;
  logic [7:0] shift_in;
  logic [7:0] tx;
  logic [2:0] bit_cnt;
  logic byte_done;
  logic rd_mode;
  logic host_ack;
  logic [7:0] ptr;
  logic [7:0] cdr_bypass_control;
  logic [7:0] rate_select_control;
  flags_s flags;
  logic [7:0] rd_byte;

  wire in_data = (st == ST_ADDR) || (st == ST_OFFS) || (st == ST_WRITE) || (st == ST_READ);
  wire at_fall_done = scl_fall & byte_done;
  wire addr_hit = shift_in[7:1] == DEV_ADDR;
  // RL12 only two bytes are writable
  wire wr_ok = (ptr == `OFF_CDR_BYPASS) || (ptr == `OFF_RATE_SELECT);
  wire wr_en = at_fall_done & (st == ST_WRITE) & wr_ok;
  wire ptr_inc = at_fall_done & ((st == ST_WRITE) || (st == ST_READ));

  // bit counting on host clock rises
  always_ff @(posedge clk) begin
    if (!rst_n || start_cond) begin
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
    end else if (scl_rise && in_data) begin
      bit_cnt <= bit_cnt + 3'h1;
      byte_done <= bit_cnt == 3'h7;
    end else if (scl_fall) begin
      byte_done <= 1'b0;
    end
  end

  // RL5 capture on rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_in <= 8'h00;
      host_ack <= 1'b0;
    end else if (scl_rise) begin
      shift_in <= {shift_in[6:0], sda_s};
      host_ack <= ~sda_s;
    end
  end

  // state walk; start and stop act while the clock is high, every other step happens on a falling clock edge
  always_ff @(posedge clk) begin
    if (!rst_n || stop_cond) begin
      st <= ST_IDLE;
      rd_mode <= 1'b0;
    end else if (start_cond) begin
      st <= ST_ADDR;
    end else if (scl_fall) begin
      unique case (st)
        ST_IDLE: st <= ST_IDLE;
        ST_ADDR: begin
          if (byte_done) begin
            st <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
            rd_mode <= shift_in[0];
          end
        end
        ST_ADDR_ACK: st <= rd_mode ? ST_READ : ST_OFFS;
        ST_OFFS: if (byte_done) st <= ST_OFFS_ACK;
        ST_OFFS_ACK: st <= ST_WRITE;
        ST_WRITE: if (byte_done) st <= ST_WRITE_ACK;
        ST_WRITE_ACK: st <= ST_WRITE;
        ST_READ: if (byte_done) st <= ST_READ_ACK;
        // a host nack ends the read, the stop follows
        ST_READ_ACK: st <= host_ack ? ST_READ : ST_IDLE;
        default: st <= ST_IDLE;
      endcase
    end
  end

  // RL9 random offset load, sequential advance
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr <= 8'h00;
    end else if (at_fall_done && st == ST_OFFS) begin
      ptr <= shift_in;
    end else if (ptr_inc) begin
      ptr <= ptr + 8'h01;
    end
  end

  // --------------------------------------------------------------
  // data line drive, open drain: only ever pulls low
  // --------------------------------------------------------------
  wire ack_slot = at_fall_done &
    ((st == ST_ADDR && addr_hit) || st == ST_OFFS || st == ST_WRITE);
  wire load_tx = scl_fall &
    ((st == ST_ADDR_ACK && rd_mode) || (st == ST_READ_ACK && host_ack));

  // RL6 change on fall
  // RL7 shared line
  always_ff @(posedge clk) begin
    if (!rst_n || start_cond || stop_cond) begin
      sda_oe <= 1'b0;
      tx <= 8'h00;
    end else if (load_tx) begin
      tx <= rd_byte;
      sda_oe <= ~rd_byte[7];
    end else if (scl_fall && st == ST_READ && !byte_done) begin
      tx <= {tx[6:0], 1'b0};
      sda_oe <= ~tx[6];
    end else if (scl_fall) begin
      sda_oe <= ack_slot;
    end
  end

  always_ff @(posedge clk) begin
    sda_out <= 1'b0;
  end

  // --------------------------------------------------------------
  // control bytes; no reset other than power-up
  // --------------------------------------------------------------
  // RL1 RL2 RL3 RL12 stored only when writable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cdr_bypass_control <= `CONTROL_RESET;
      rate_select_control <= `CONTROL_RESET;
    end else if (wr_en && ptr == `OFF_CDR_BYPASS) begin
      cdr_bypass_control <= shift_in;
    end else if (wr_en && ptr == `OFF_RATE_SELECT) begin
      rate_select_control <= shift_in;
    end
  end

  // RL1 RL2 apply settings
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_8g <= 1'b0;
      cdr_bypass <= 1'b0;
    end else begin
      rate_8g <= rate_select_control[`RATE_8G_BIT];
      cdr_bypass <= cdr_bypass_control[`CDR_BYPASS_BIT];
    end
  end

  // --------------------------------------------------------------
  // monitors and flags
  // --------------------------------------------------------------
  wire [4:0][15:0] mon = monitors;
  localparam logic [4:0][15:0] AHI = `LIMIT_ALARM_HI;
  localparam logic [4:0][15:0] ALO = `LIMIT_ALARM_LO;
  localparam logic [4:0][15:0] WHI = `LIMIT_WARN_HI;
  localparam logic [4:0][15:0] WLO = `LIMIT_WARN_LO;

  // RL11 per-channel compare
  for (genvar i = 0; i < 5; i++) begin : g_chan
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        {flags.alarm_hi[i], flags.alarm_lo[i], flags.warn_hi[i], flags.warn_lo[i]} <= 4'h0;
      end else begin
        {flags.alarm_hi[i], flags.alarm_lo[i], flags.warn_hi[i], flags.warn_lo[i]} <=
          {mon[i] > AHI[i], mon[i] < ALO[i], mon[i] > WHI[i], mon[i] < WLO[i]};
      end
    end
  end

  // summary pins lag the flags by one clock
  always_ff @(posedge clk) begin
    if (!rst_n) {alarm_any, warn_any} <= 2'h0;
    else {alarm_any, warn_any} <= {|{flags.alarm_hi, flags.alarm_lo}, |{flags.warn_hi, flags.warn_lo}};
  end

  // RL10 read map, live values sampled at byte load
  wire mon_hit = (ptr[7:4] == `MON_PAGE) && (ptr[3:0] <= `MON_LAST);
  wire [2:0] mon_idx = 3'h4 - ptr[3:1];
  wire [15:0] mon_word = mon[mon_idx];
  wire [7:0] mon_byte = ptr[0] ? mon_word[7:0] : mon_word[15:8];
  assign rd_byte =
    mon_hit ? mon_byte :
    (ptr == `OFF_ALARM_HI) ? {3'h0, flags.alarm_hi} :
    (ptr == `OFF_ALARM_LO) ? {3'h0, flags.alarm_lo} :
    (ptr == `OFF_WARN_HI) ? {3'h0, flags.warn_hi} :
    (ptr == `OFF_WARN_LO) ? {3'h0, flags.warn_lo} :
    (ptr == `OFF_CDR_BYPASS) ? cdr_bypass_control :
    (ptr == `OFF_RATE_SELECT) ? rate_select_control : 8'h00;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  property p_rate_write;
    @(posedge clk) disable iff (!rst_n)
    (wr_en && ptr == `OFF_RATE_SELECT) |=> ##1 (rate_8g == $past(shift_in[0], 2));
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("rate bit not applied"); // RL1
  property p_cdr_write;
    @(posedge clk) disable iff (!rst_n)
    (wr_en && ptr == `OFF_CDR_BYPASS) |=> ##1 (cdr_bypass == $past(shift_in[0], 2));
  endproperty
  a_cdr_write: assert property (p_cdr_write) else $error("bypass bit not applied"); // RL2
  property p_reset_default;
    @(posedge clk) !rst_n ##1 !rst_n |=> (!rate_8g && !cdr_bypass && !sda_oe);
  endproperty
  a_reset_default: assert property (p_reset_default) else $error("reset defaults wrong"); // RL3
  property p_capture_rise;
    @(posedge clk) disable iff (!rst_n)
    scl_rise |=> (shift_in[0] == $past(sda_s));
  endproperty
  a_capture_rise: assert property (p_capture_rise) else $error("data not captured"); // RL5
  property p_drive_on_fall;
    @(posedge clk) disable iff (!rst_n)
    $rose(sda_oe) |-> $past(scl_fall);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("data changed off fall"); // RL6
  property p_drive_states;
    @(posedge clk) disable iff (!rst_n)
    sda_oe |-> (st == ST_ADDR_ACK || st == ST_OFFS_ACK || st == ST_WRITE_ACK || st == ST_READ);
  endproperty
  a_drive_states: assert property (p_drive_states) else $error("line driven out of turn"); // RL7
  property p_seq_advance;
    @(posedge clk) disable iff (!rst_n)
    (at_fall_done && st == ST_READ) |=> (ptr == $past(ptr) + 8'h01);
  endproperty
  a_seq_advance: assert property (p_seq_advance) else $error("pointer did not advance"); // RL9
  property p_alarm_flag;
    @(posedge clk) disable iff (!rst_n)
    (monitors.temperature > AHI[4]) ##1 (monitors.temperature > AHI[4]) |-> ##1 alarm_any;
  endproperty
  a_alarm_flag: assert property (p_alarm_flag) else $error("alarm not raised"); // RL11
  property p_protect;
    @(posedge clk) disable iff (!rst_n)
    (at_fall_done && st == ST_WRITE && !wr_ok) |=>
      ($stable(cdr_bypass_control) && $stable(rate_select_control) && st == ST_WRITE_ACK);
  endproperty
  a_protect: assert property (p_protect) else $error("protected write took effect"); // RL12

endmodule // transceiver_mgmt_rate_select

// ==== core/mgmt_defs.svh ====
`ifndef MGMT_DEFS_SVH
`define MGMT_DEFS_SVH

// --------------------------------------------------------------
// management memory offsets
// --------------------------------------------------------------
`define OFF_CDR_BYPASS 8'h6f
`define OFF_RATE_SELECT 8'h75
`define OFF_ALARM_HI 8'h50
`define OFF_ALARM_LO 8'h51
`define OFF_WARN_HI 8'h52
`define OFF_WARN_LO 8'h53
// monitor words sit big-endian at 0x60..0x69
`define MON_PAGE 4'h6
`define MON_LAST 4'h9

// --------------------------------------------------------------
// fields and reset values
// --------------------------------------------------------------
`define RATE_8G_BIT 0
`define CDR_BYPASS_BIT 0
`define CONTROL_RESET 8'h00
`define DEV_ADDR_DEFAULT 7'h50

// --------------------------------------------------------------
// factory limits, one 16-bit word per channel
// order: temperature, bias, tx power, rx power, supply
// --------------------------------------------------------------
`define LIMIT_ALARM_HI 80'h5000_c000_c000_c000_9000
`define LIMIT_ALARM_LO 80'h0400_0400_0400_0400_7000
`define LIMIT_WARN_HI 80'h4800_b000_b000_b000_8c00
`define LIMIT_WARN_LO 80'h0800_0800_0800_0800_7400

`endif

// ==== core/mgmt_pkg.sv ====
package mgmt_pkg;

  // --------------------------------------------------------------
  // link engine states
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h2,
    ST_OFFS      = 4'h3,
    ST_OFFS_ACK  = 4'h4,
    ST_WRITE     = 4'h5,
    ST_WRITE_ACK = 4'h6,
    ST_READ      = 4'h7,
    ST_READ_ACK  = 4'h8
  } link_state_e;

  // live measurements, temperature in the top word
  typedef struct packed {
    logic [15:0] temperature;
    logic [15:0] bias;
    logic [15:0] tx_power;
    logic [15:0] rx_power;
    logic [15:0] supply;
  } monitors_s;

  // one bit per channel, bit 4 is temperature
  typedef struct packed {
    logic [4:0] alarm_hi;
    logic [4:0] alarm_lo;
    logic [4:0] warn_hi;
    logic [4:0] warn_lo;
  } flags_s;

endpackage

// ==== core/pin_sync.sv ====
`timescale 1ns/100ps

// two-stage synchroniser for pins from outside the clock domain
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] sync
);

  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_check
    $error("pin_sync needs at least one bit");
  end

  // first stage feeds only the second; idle lines sit high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '1;
      sync <= '1;
    end else begin
      meta <= pin;
      sync <= meta;
    end
  end

endmodule // pin_sync

// ==== verification/mgmt_host.sv ====
`timescale 1ns/100ps

// host end of the two-wire link; only the host makes the clock
module mgmt_host (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  logic r;

  // idle: clock stands high, data released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // host clock, open drain
  // data set in low phase, sampled mid high phase to keep clear of the device lag
  task automatic bit_io(input logic b, output logic s);
    @(posedge clk) sda_drv <= b;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (2) @(posedge clk);
    s = sda_wire;
    repeat (2) @(posedge clk);
    scl <= 1'b0;
  endtask

  // start and stop
  // data moves while clock high; start also serves as repeated start
  task automatic frame(input logic stop);
    @(posedge clk) sda_drv <= ~stop;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    sda_drv <= stop;
    repeat (4) @(posedge clk);
    scl <= stop;
  endtask

  // msb first; acknowledge is the wire low on the ninth bit
  task automatic put(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // last byte of a read is answered by releasing the wire
  task automatic get(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // mgmt_host

// ==== verification/transceiver_mgmt_rate_select_bench.sv ====
`timescale 1ns/100ps
`include "mgmt_defs.svh"

module transceiver_mgmt_rate_select_bench
  import mgmt_pkg::*;
();
  localparam logic [79:0] AH = `LIMIT_ALARM_HI;
  localparam logic [79:0] AL = `LIMIT_ALARM_LO;
  localparam logic [79:0] WH = `LIMIT_WARN_HI;
  localparam logic [79:0] WL = `LIMIT_WARN_LO;
  localparam logic [7:0] WA = {`DEV_ADDR_DEFAULT, 1'b0};
  logic clk = 1'b0;
  logic rst_n;
  monitors_s mon;
  logic scl, sda_drv, sda_out, sda_oe, rate_8g, cdr_bypass, alarm_any, warn_any;
  logic ack, scl_q, oe_q;
  int errors = 0;
  int cmp_count = 0;

  // 10 MHz system clock
  always #50 clk = ~clk;

  wire logic sda_wire = sda_drv & ~(sda_oe & ~sda_out);

  mgmt_host host (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

  transceiver_mgmt_rate_select DUT (.clk(clk), .rst_n(rst_n), .scl(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .monitors(mon),
    .rate_8g(rate_8g), .cdr_bypass(cdr_bypass), .alarm_any(alarm_any),
    .warn_any(warn_any));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // compare and count; an unknown matches only an unknown in the same bit
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic want);
    host.put(b, ack);
    check(16'(ack), 16'(want), "ack");
  endtask

  task automatic wr(input logic [7:0] off, input logic [7:0] d [$]);
    host.frame(1'b0);
    send(WA, 1'b1);
    send(off, 1'b1);
    foreach (d[i]) send(d[i], 1'b1);
    host.frame(1'b1);
  endtask

  // random read: pointer set by a dummy write, then repeated start
  task automatic rd(input logic [7:0] off, input int n, output logic [7:0] q [$]);
    logic [7:0] b;
    q = {};
    host.frame(1'b0);
    send(WA, 1'b1);
    send(off, 1'b1);
    host.frame(1'b0);
    send(WA | 8'h01, 1'b1);
    for (int i = 0; i < n; i++) begin
      host.get(i == n - 1, b);
      q.push_back(b);
    end
    host.frame(1'b1);
  endtask

  // strict compares against each factory limit
  function automatic flags_s exp_flags(logic [79:0] v);
    flags_s f;
    for (int c = 0; c < 5; c++) begin
      f.alarm_hi[c] = v[c*16+:16] > AH[c*16+:16];
      f.alarm_lo[c] = v[c*16+:16] < AL[c*16+:16];
      f.warn_hi[c] = v[c*16+:16] > WH[c*16+:16];
      f.warn_lo[c] = v[c*16+:16] < WL[c*16+:16];
    end
    return f;
  endfunction

  // flags from 0x50, monitor words from 0x60 when n reaches them
  task automatic check_mon(input int n);
    flags_s f;
    logic [7:0] q [$];
    f = exp_flags(mon);
    rd(`OFF_ALARM_HI, n, q);
    check(16'(q[0]), 16'(f.alarm_hi), "alarm hi");
    check(16'(q[1]), 16'(f.alarm_lo), "alarm lo");
    check(16'(q[2]), 16'(f.warn_hi), "warn hi");
    check(16'(q[3]), 16'(f.warn_lo), "warn lo");
    check(16'(alarm_any), 16'(|{f.alarm_hi, f.alarm_lo}), "alarm any");
    check(16'(warn_any), 16'(|{f.warn_hi, f.warn_lo}), "warn any");
    for (int i = 16; i < n; i++) check(16'(q[i]), 16'(mon[207-8*i-:8]), "monitor");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (rst_n && scl && scl_q && sda_oe !== oe_q) begin
      errors++;
      $display("wrong value at %0t ns: data moved with clock high", $time);
    end
    scl_q <= scl;
    oe_q <= sda_oe;
  end

  // hang guard: the tests take some 32000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    $display("wrong value at %0t ns: watchdog ran out", $time);
    wrap_up();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [7:0] q [$];
    logic [7:0] d;
    logic [79:0] v;
    logic [15:0] cv [6];
    rst_n <= 1'b0;
    mon <= '0;
    void'($urandom(21151));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(16'({rate_8g, cdr_bypass}), 16'h0, "reset");
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 8'h01 : (i == 1) ? 8'hfe : 8'($urandom);
      wr(`OFF_RATE_SELECT, {d});
      check(16'(rate_8g), 16'(d[0]), "rate");
      wr(`OFF_CDR_BYPASS, {~d});
      check(16'(cdr_bypass), {15'h0, ~d[0]}, "bypass");
      rd(`OFF_CDR_BYPASS, 7, q);
      check(16'(q[0]), {8'h00, ~d}, "bypass byte");
      check(16'(q[6]), 16'(d), "rate byte");
    end
    $display("test rate select done");
    d = 8'($urandom);
    wr(8'h74, {8'h5a, d, 8'ha5});
    rd(8'h74, 3, q);
    check(16'({q[0], q[2]}), 16'h0, "protected");
    check(16'(q[1]), 16'(d), "sequential");
    host.frame(1'b0);
    send(WA ^ 8'h02, 1'b0);
    send(`OFF_RATE_SELECT, 1'b0);
    send(~d, 1'b0);
    host.frame(1'b1);
    check(16'(rate_8g), 16'(d[0]), "foreign");
    $display("test protection done");
    wr(`OFF_RATE_SELECT, {8'h01});
    wr(`OFF_CDR_BYPASS, {8'h01});
    @(posedge clk) rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`OFF_CDR_BYPASS, 7, q);
    check(16'({rate_8g, cdr_bypass}), 16'h0, "defaults");
    check({q[0], q[6]}, 16'h0, "default bytes");
    $display("test power cycle done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) mon <= 80'({$urandom, $urandom, $urandom});
      repeat (4) @(posedge clk);
      check_mon(26);
    end
    $display("test monitors done");
    // at and just past each alarm bound, just past each warning bound
    for (int c = 0; c < 5; c++) begin
      for (int j = 0; j < 6; j++) begin
        for (int k = 0; k < 5; k++)
          v[k*16+:16] = WL[k*16+:16] + 16'h1 + 16'($urandom % 32'(WH[k*16+:16] - WL[k*16+:16] - 16'h1));
        cv = '{AH[c*16+:16], AH[c*16+:16] + 16'h1, WH[c*16+:16] + 16'h1,
               WL[c*16+:16] - 16'h1, AL[c*16+:16] - 16'h1, AL[c*16+:16]};
        v[c*16+:16] = cv[j];
        @(posedge clk) mon <= v;
        repeat (4) @(posedge clk);
        check_mon(4);
      end
    end
    $display("test limits done");
    wrap_up();
  end
endmodule // transceiver_mgmt_rate_select_bench
